// >>> core/lookup_defines.svh
// register offsets, reset values, field positions and mode codes of the lookup decoder
`ifndef LOOKUP_DEFINES_SVH
`define LOOKUP_DEFINES_SVH

`define LK_ADDR_MODE        8'h10
`define LK_ADDR_TABLE_ZERO  8'h11
`define LK_ADDR_TABLE_ONE   8'h12
`define LK_ADDR_TABLE_TWO   8'h13
`define LK_ADDR_TABLE_THREE 8'h14
`define LK_ADDR_TABLE_FOUR  8'h15

`define LK_RESET_BYTE       8'h00
`define LK_UNMAPPED_BYTE    8'h00

`define LK_UPPER_SEL_HI     7
`define LK_UPPER_SEL_LO     4
`define LK_LOWER_SEL_HI     1
`define LK_LOWER_SEL_LO     0
`define LK_UPPER_FIELD      5:4
`define LK_LOWER_FIELD      1:0

`define LK_MODE_OFF         2'h0
`define LK_MODE_TWO_IN      2'h1
`define LK_MODE_THREE_IN    2'h2
`define LK_MODE_THREE_TWO   2'h3

`define LK_UPPER_2IN_OUT    6
`define LK_UPPER_2IN_IDX    5:4
`define LK_UPPER_3IN_OUT    7
`define LK_UPPER_3IN_IDX    6:4
`define LK_LOWER_2IN_OUT    2
`define LK_LOWER_2IN_IDX    1:0
`define LK_LOWER_3IN_OUT    3
`define LK_LOWER_3IN_IDX    2:0
`define LK_LOWER_32_OUT_LO  3
`define LK_LOWER_32_OUT_HI  4

`define LK_T0_UPPER_BASE    3'h4
`define LK_T0_LOWER_BASE    3'h0

`endif

// >>> core/lookup_pkg.sv
// shared types of the lookup decoder
package lookup_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [1:0] sel_t;

    typedef enum logic [1:0] {
        MODE_OFF       = 2'h0,
        MODE_TWO_IN    = 2'h1,
        MODE_THREE_IN  = 2'h2,
        MODE_THREE_TWO = 2'h3
    } lookup_mode_t;

endpackage : lookup_pkg

// >>> core/lookup_if.sv
// carrier between the register side and the table decoder
interface lookup_if;
    lookup_pkg::byte_t table_zero;
    lookup_pkg::byte_t table_one;
    lookup_pkg::byte_t table_two;
    lookup_pkg::byte_t table_three;
    lookup_pkg::byte_t table_four;
    lookup_pkg::sel_t  upper_sel;
    lookup_pkg::sel_t  lower_sel;
    lookup_pkg::byte_t pins;
    lookup_pkg::byte_t dec_val;
    lookup_pkg::byte_t dec_en;

    modport ctrl (
        output table_zero, table_one, table_two, table_three, table_four,
        output upper_sel, lower_sel, pins,
        input  dec_val, dec_en
    );
    modport dec (
        input  table_zero, table_one, table_two, table_three, table_four,
        input  upper_sel, lower_sel, pins,
        output dec_val, dec_en
    );
endinterface : lookup_if

// >>> core/lookup_table_decode.sv
// combinational table lookup for both nibbles of the bank
`include "lookup_defines.svh"

module lookup_table_decode (
    lookup_if.dec lk
);

    function automatic logic pick(input lookup_pkg::byte_t tbl, input logic [2:0] idx);
        pick = tbl[idx];
    endfunction : pick

    // pure lookup from current pin levels, no register in the path
    always_comb begin
        lk.dec_val = `LK_RESET_BYTE;
        lk.dec_en  = `LK_RESET_BYTE;
        unique case (lk.upper_sel)
            `LK_MODE_OFF: begin
            end
            `LK_MODE_TWO_IN: begin
                // upper half of table zero, bit 7 for pattern 11 down to bit 4 for 00
                lk.dec_val[`LK_UPPER_2IN_OUT] = pick(lk.table_zero,
                    `LK_T0_UPPER_BASE + {1'b0, lk.pins[`LK_UPPER_2IN_IDX]});
                lk.dec_en[`LK_UPPER_2IN_OUT]  = 1'b1;
            end
            `LK_MODE_THREE_IN: begin
                lk.dec_val[`LK_UPPER_3IN_OUT] = pick(lk.table_one, lk.pins[`LK_UPPER_3IN_IDX]);
                lk.dec_en[`LK_UPPER_3IN_OUT]  = 1'b1;
            end
            `LK_MODE_THREE_TWO: begin
                // reserved code: left as plain gpio
            end
        endcase
        unique case (lk.lower_sel)
            `LK_MODE_OFF: begin
            end
            `LK_MODE_TWO_IN: begin
                lk.dec_val[`LK_LOWER_2IN_OUT] = pick(lk.table_zero,
                    `LK_T0_LOWER_BASE + {1'b0, lk.pins[`LK_LOWER_2IN_IDX]});
                lk.dec_en[`LK_LOWER_2IN_OUT]  = 1'b1;
            end
            `LK_MODE_THREE_IN: begin
                lk.dec_val[`LK_LOWER_3IN_OUT] = pick(lk.table_two, lk.pins[`LK_LOWER_3IN_IDX]);
                lk.dec_en[`LK_LOWER_3IN_OUT]  = 1'b1;
            end
            `LK_MODE_THREE_TWO: begin
                lk.dec_val[`LK_LOWER_32_OUT_LO] = pick(lk.table_three, lk.pins[`LK_LOWER_3IN_IDX]);
                lk.dec_val[`LK_LOWER_32_OUT_HI] = pick(lk.table_four, lk.pins[`LK_LOWER_3IN_IDX]);
                lk.dec_en[`LK_LOWER_32_OUT_LO]  = 1'b1;
                lk.dec_en[`LK_LOWER_32_OUT_HI]  = 1'b1;
            end
        endcase
    end

endmodule : lookup_table_decode

// >>> core/gpio_lookup_logic_decoder.sv
// lookup-table logic of an 8-line gpio bank: mode and table registers plus pin override
// Operation
// - upper mode 00 leaves lines 7..4 as plain gpio, except line 4 while lower mode is 11.
// - upper mode 01 drives line 6 from table zero indexed by lines 5..4.
// - upper mode 10 drives line 7 from table one indexed by lines 6..4.
// - lower mode 00 leaves lines 3..0 as plain gpio.
// - lower mode 01 drives line 2 from table zero indexed by lines 1..0.
// - lower mode 10 drives line 3 from table two indexed by lines 2..0.
// - lower mode 11 drives lines 4 and 3 from decoded tables, indexed by 2..0.
// - table zero bits 7..4 give line 6 for patterns 11, 10, 01, 00.
// - table zero upper bits matter only in upper two-input mode.
`include "lookup_defines.svh"

module gpio_lookup_logic_decoder (
    input  wire logic              core_clk,
    input  wire logic              rst,
    // register port from the serial slave
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output lookup_pkg::byte_t      reg_rdata,
    output logic                   reg_rvalid,
    // plain gpio levels from the expander core
    input  wire logic [7:0]        gpio_data,
    input  wire logic [7:0]        gpio_dir_out,
    // pad side
    input  wire logic [7:0]        io_in,
    output logic      [7:0]        io_out,
    output logic      [7:0]        io_oe,
    output logic      [7:0]        lookup_active
);

    lookup_pkg::byte_t   mode_r;
    lookup_pkg::byte_t   mode_nxt;
    lookup_pkg::byte_t   table_zero_r;
    lookup_pkg::byte_t   table_zero_nxt;
    lookup_pkg::byte_t   table_one_r;
    lookup_pkg::byte_t   table_one_nxt;
    lookup_pkg::byte_t   table_two_r;
    lookup_pkg::byte_t   table_two_nxt;
    lookup_pkg::byte_t   table_three_r;
    lookup_pkg::byte_t   table_three_nxt;
    lookup_pkg::byte_t   table_four_r;
    lookup_pkg::byte_t   table_four_nxt;
    lookup_pkg::byte_t   rdata_r;
    lookup_pkg::byte_t   rdata_nxt;
    logic                rvalid_r;
    logic                rvalid_nxt;
    lookup_pkg::lookup_mode_t upper_mode;
    lookup_pkg::lookup_mode_t lower_mode;
    logic                wr_mode;
    logic                wr_table_zero;
    logic                wr_table_one;
    logic                wr_table_two;
    logic                wr_table_three;
    logic                wr_table_four;

    lookup_if lk ();

    // address compare shared by the write strobes and the read mux
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
        reg_hit = (addr == target);
    endfunction : reg_hit

    // register read mux, also used to answer unmapped addresses
    function automatic lookup_pkg::byte_t read_mux(input logic [7:0] addr,
                                                   input lookup_pkg::byte_t m,
                                                   input lookup_pkg::byte_t t0,
                                                   input lookup_pkg::byte_t t1,
                                                   input lookup_pkg::byte_t t2,
                                                   input lookup_pkg::byte_t t3,
                                                   input lookup_pkg::byte_t t4);
        lookup_pkg::byte_t v;
        v = `LK_UNMAPPED_BYTE;
        if (reg_hit(addr, `LK_ADDR_MODE)) begin
            v = m;
        end
        if (reg_hit(addr, `LK_ADDR_TABLE_ZERO)) begin
            v = t0;
        end
        if (reg_hit(addr, `LK_ADDR_TABLE_ONE)) begin
            v = t1;
        end
        if (reg_hit(addr, `LK_ADDR_TABLE_TWO)) begin
            v = t2;
        end
        if (reg_hit(addr, `LK_ADDR_TABLE_THREE)) begin
            v = t3;
        end
        if (reg_hit(addr, `LK_ADDR_TABLE_FOUR)) begin
            v = t4;
        end
        read_mux = v;
    endfunction : read_mux

    // one strobe per register; a write to an unmapped address raises none of them
    assign wr_mode        = reg_wr && reg_hit(reg_addr, `LK_ADDR_MODE);
    assign wr_table_zero  = reg_wr && reg_hit(reg_addr, `LK_ADDR_TABLE_ZERO);
    assign wr_table_one   = reg_wr && reg_hit(reg_addr, `LK_ADDR_TABLE_ONE);
    assign wr_table_two   = reg_wr && reg_hit(reg_addr, `LK_ADDR_TABLE_TWO);
    assign wr_table_three = reg_wr && reg_hit(reg_addr, `LK_ADDR_TABLE_THREE);
    assign wr_table_four  = reg_wr && reg_hit(reg_addr, `LK_ADDR_TABLE_FOUR);

    // register writes: whole byte stored, reserved mode bits kept as written
    always_comb begin
        mode_nxt        = mode_r;
        table_zero_nxt  = table_zero_r;
        table_one_nxt   = table_one_r;
        table_two_nxt   = table_two_r;
        table_three_nxt = table_three_r;
        table_four_nxt  = table_four_r;
        if (wr_mode) begin
            mode_nxt = reg_wdata;
        end
        if (wr_table_zero) begin
            table_zero_nxt = reg_wdata;
        end
        if (wr_table_one) begin
            table_one_nxt = reg_wdata;
        end
        if (wr_table_two) begin
            table_two_nxt = reg_wdata;
        end
        if (wr_table_three) begin
            table_three_nxt = reg_wdata;
        end
        if (wr_table_four) begin
            table_four_nxt = reg_wdata;
        end
    end

    // every register clears to zero, so both nibbles leave reset as plain gpio
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_r        <= `LK_RESET_BYTE;
            table_zero_r  <= `LK_RESET_BYTE;
            table_one_r   <= `LK_RESET_BYTE;
            table_two_r   <= `LK_RESET_BYTE;
            table_three_r <= `LK_RESET_BYTE;
            table_four_r  <= `LK_RESET_BYTE;
        end else begin
            mode_r        <= mode_nxt;
            table_zero_r  <= table_zero_nxt;
            table_one_r   <= table_one_nxt;
            table_two_r   <= table_two_nxt;
            table_three_r <= table_three_nxt;
            table_four_r  <= table_four_nxt;
        end
    end

    // read data is captured on the edge that samples the strobe; a same-cycle write is not yet visible
    always_comb begin
        rvalid_nxt = reg_rd;
        rdata_nxt  = rdata_r;
        if (reg_rd) begin
            rdata_nxt = read_mux(reg_addr, mode_r, table_zero_r, table_one_r,
                                 table_two_r, table_three_r, table_four_r);
        end
    end

    // rvalid is reg_rd delayed by one cycle; rdata holds until the next read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r  <= `LK_RESET_BYTE;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata  = rdata_r;
    assign reg_rvalid = rvalid_r;

    // mode field of one nibble of the mode register
    function automatic lookup_pkg::lookup_mode_t nibble_mode(input lookup_pkg::byte_t m, input logic upper);
        if (upper) begin
            nibble_mode = lookup_pkg::lookup_mode_t'(m[`LK_UPPER_FIELD]);
        end else begin
            nibble_mode = lookup_pkg::lookup_mode_t'(m[`LK_LOWER_FIELD]);
        end
    endfunction : nibble_mode

    // mode fields; the reserved upper code 11 decodes to nothing
    assign upper_mode = nibble_mode(mode_r, 1'b1);
    assign lower_mode = nibble_mode(mode_r, 1'b0);

    assign lk.table_zero  = table_zero_r;
    assign lk.table_one   = table_one_r;
    assign lk.table_two   = table_two_r;
    assign lk.table_three = table_three_r;
    assign lk.table_four  = table_four_r;
    assign lk.upper_sel   = upper_mode;
    assign lk.lower_sel   = lower_mode;
    // index comes from the pad level, so a decoded line may itself index another decode
    assign lk.pins        = io_in;

    lookup_table_decode u_decode (
        .lk (lk.dec)
    );

    // pad mux: a decoded line is forced to output, others keep their gpio setting;
    // the path from io_in to io_out is combinational, so the board must not loop them
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (lk.dec_en[i]) begin
                io_out[i] = lk.dec_val[i];
                io_oe[i]  = 1'b1;
            end else begin
                io_out[i] = gpio_data[i];
                io_oe[i]  = gpio_dir_out[i];
            end
        end
    end

    assign lookup_active = lk.dec_en;

endmodule : gpio_lookup_logic_decoder

// >>> tb/lookup_assertions.sv
// port-level assertions of the lookup decoder
module lookup_assertions (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire lookup_pkg::byte_t reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic [7:0]        gpio_data,
    input wire logic [7:0]        gpio_dir_out,
    input wire logic [7:0]        io_in,
    input wire logic [7:0]        io_out,
    input wire logic [7:0]        io_oe,
    input wire logic [7:0]        lookup_active
);
    timeunit 1ns;
    timeprecision 1ps;
    lookup_pkg::byte_t m_r;
    lookup_pkg::byte_t t_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // shadows of the mode and table zero registers
    always_ff @(posedge core_clk) m_r <= rst ? 8'h00 : (reg_wr && reg_addr == 8'h10) ? reg_wdata : m_r;
    always_ff @(posedge core_clk) t_r <= rst ? 8'h00 : (reg_wr && reg_addr == 8'h11) ? reg_wdata : t_r;
    sequence s_wr_tab;
        reg_wr && reg_addr == 8'h11;
    endsequence
    sequence s_rd_tab;
        reg_rd && !reg_wr && reg_addr == 8'h11;
    endsequence
    // the bench leaves one idle cycle after each write before the read
    property p_wr_rd;
        lookup_pkg::byte_t d;
        (s_wr_tab, d = reg_wdata) ##1 !(reg_wr && reg_addr == 8'h11) ##1 s_rd_tab |=> reg_rdata == d;
    endproperty
    AST_RD_VALID: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    AST_NO_SPUR: assert property (!reg_rd |=> !reg_rvalid) else $error("spurious read valid");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h15 |=> reg_rdata == 8'h00) else $error("unmapped read");
    AST_WR_RD: assert property (p_wr_rd) else $error("table zero read back wrong");
    AST_UP_OFF: assert property (m_r[5:4] == 2'h0 && m_r[1:0] != 2'h3 |-> io_out[7:4] == gpio_data[7:4]
        && io_oe[7:4] == gpio_dir_out[7:4] && lookup_active[7:4] == 4'h0) else $error("upper plain gpio");
    AST_UP_TWO: assert property (m_r[5:4] == 2'h1 |-> io_oe[6] && io_out[6] == t_r[4 + io_in[5:4]])
        else $error("upper two-input decode");
    AST_LO_OFF: assert property (m_r[1:0] == 2'h0 |-> io_out[3:0] == gpio_data[3:0]
        && io_oe[3:0] == gpio_dir_out[3:0]) else $error("lower plain gpio");
    AST_LO_TWO: assert property (m_r[1:0] == 2'h1 |-> io_oe[2] && io_out[2] == t_r[io_in[1:0]])
        else $error("lower two-input decode");
    AST_T0_HI: assert property (m_r[5:4] != 2'h1 |-> !lookup_active[6])
        else $error("table zero upper half reaches a pad");
endmodule : lookup_assertions

bind gpio_lookup_logic_decoder lookup_assertions lookup_assertions_i (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .gpio_data(gpio_data), .gpio_dir_out(gpio_dir_out), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .lookup_active(lookup_active));

// >>> tb/pin_partner.sv
// external devices on the pads: a driven pad reads back its own level, others see the device level
module pin_partner (
    input  wire logic [7:0] io_out,
    input  wire logic [7:0] io_oe,
    input  wire logic [7:0] ext,
    output logic      [7:0] io_in
);
    timeunit 1ns;
    timeprecision 1ps;
    assign io_in = (io_oe & io_out) | (~io_oe & ext);
endmodule : pin_partner

// >>> tb/gpio_lookup_logic_decoder_bench.sv
// self-checking bench of the lookup decoder
module gpio_lookup_logic_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] T0 = 8'hA5, T1 = 8'h96, T2 = 8'h3C, T3 = 8'hE1, T4 = 8'h4B;
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [7:0]        reg_addr = 8'h00;
    logic [7:0]        reg_wdata = 8'h00;
    logic [7:0]        gpio_data = 8'h5A;
    logic [7:0]        gpio_dir_out = 8'hF0;
    logic [7:0]        ext = 8'h00;
    lookup_pkg::byte_t reg_rdata;
    logic              reg_rvalid;
    logic [7:0]        io_in, io_out, io_oe, lookup_active;
    int                err_count = 0;
    int                checks = 0;
    always #4 core_clk = ~core_clk;
    gpio_lookup_logic_decoder gpio_lookup_logic_decoder_i (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .gpio_data(gpio_data), .gpio_dir_out(gpio_dir_out), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .lookup_active(lookup_active));
    pin_partner pin_partner_i (.io_out(io_out), .io_oe(io_oe), .ext(ext), .io_in(io_in));
    task summarize();
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    // both tasks are entered at a falling edge and return at one;
    // a strobe stays low for a whole cycle before the next one rises
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        @(negedge core_clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        check("rvalid", 8'(reg_rvalid), 8'h01);
        check("rdata", reg_rdata, exp);
        @(negedge core_clk);
        check("rvalid", 8'(reg_rvalid), 8'h00);
    endtask : rd
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        summarize();
    end
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        check("oe", io_oe, 8'hF0);
        check("out", io_out, 8'h5A);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h00);
        // external devices drive every index line from here on
        gpio_dir_out = 8'h00;
        wr(8'h11, T0);
        rd(8'h11, T0);
        wr(8'h10, 8'h11);
        check("active", lookup_active, 8'h44);
        for (int i = 0; i < 4; i++) begin
            ext = {2'h0, i[1:0], 2'h0, i[1:0]};
            #1;
            check("line6", 8'(io_out[6]), 8'(T0[4 + i]));
            check("line2", 8'(io_out[2]), 8'(T0[i]));
            @(negedge core_clk);
        end
        wr(8'h12, T1);
        wr(8'h13, T2);
        wr(8'h10, 8'h22);
        check("active", lookup_active, 8'h88);
        for (int i = 0; i < 8; i++) begin
            ext = {1'b0, i[2:0], 1'b0, i[2:0]};
            #1;
            check("line7", 8'(io_out[7] & io_oe[7]), 8'(T1[i]));
            check("line3", 8'(io_out[3] & io_oe[3]), 8'(T2[i]));
            @(negedge core_clk);
        end
        wr(8'h14, T3);
        wr(8'h15, T4);
        wr(8'h10, 8'h03);
        check("active", lookup_active, 8'h18);
        for (int i = 0; i < 8; i++) begin
            ext = {5'h00, i[2:0]};
            #1;
            check("line3", 8'(io_out[3]), 8'(T3[i]));
            check("line4", 8'(io_out[4] & io_oe[4]), 8'(T4[i]));
            @(negedge core_clk);
        end
        // table zero stays loaded, yet with both decodes off no pad may follow it
        gpio_dir_out = 8'hF0;
        wr(8'h10, 8'h00);
        rd(8'h10, 8'h00);
        check("active", lookup_active, 8'h00);
        check("oe", io_oe, 8'hF0);
        check("out", io_out, 8'h5A);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        rd(8'h11, T0);
        summarize();
    end
endmodule : gpio_lookup_logic_decoder_bench
